/* File: common/pic_pkg.sv */
package pic_pkg;

  // ------------------------------------------------------------
  // Register map (APB byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] PIC_OFS_FLAGS    = 8'h00;
  localparam logic [7:0] PIC_OFS_PENDING  = 8'h04;
  localparam logic [7:0] PIC_OFS_ACTIVE   = 8'h08;
  localparam logic [7:0] PIC_OFS_SRC_MASK = 8'h0C;
  localparam logic [7:0] PIC_OFS_CMD      = 8'h10;
  localparam logic [7:0] PIC_OFS_ALU      = 8'h14;
  localparam logic [7:0] PIC_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] PIC_OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] PIC_OFS_VECTOR   = 8'h20;

  // ------------------------------------------------------------
  // Condition flag bit positions
  // ------------------------------------------------------------
  localparam int PIC_FLAG_BRANCH = 0;
  localparam int PIC_FLAG_CARRY  = 1;
  localparam int PIC_FLAG_IE     = 2;

  // ------------------------------------------------------------
  // Source mask bit positions
  // ------------------------------------------------------------
  localparam int PIC_SRC_EEPROM = 0;
  localparam int PIC_SRC_P3L0   = 1;
  localparam int PIC_SRC_P3L1   = 2;
  localparam int PIC_SRC_P3L2   = 3;
  localparam int PIC_SRC_P3L3   = 4;
  localparam int PIC_SRC_TMR1   = 5;
  localparam int PIC_SRC_TAS    = 6;
  localparam int PIC_SRC_TAP    = 7;
  localparam int PIC_SRC_TBS    = 8;
  localparam int PIC_SRC_TBP    = 9;
  localparam int PIC_SRC_IN40   = 10;
  localparam int PIC_NUM_SRC    = 11;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [3:0]  PIC_FLAGS_RST     = 4'h0;
  localparam logic [10:0] PIC_SRC_MASK_RST  = 11'h000;
  localparam logic [1:0]  PIC_SYSCLK_PER_MC = 2'h2;
  localparam logic [1:0]  PIC_LONG_INSTR_MC = 2'h3;

  // Command codes written to the command register.
  typedef enum logic [3:0] {
    PIC_CMD_NOP      = 4'h0,
    PIC_CMD_IRQ_OFF  = 4'h1,
    PIC_CMD_IRQ_ON   = 4'h2,
    PIC_CMD_RETURN   = 4'h3,
    PIC_CMD_SLEEP    = 4'h4,
    PIC_CMD_SOFT_IRQ = 4'h5,
    PIC_CMD_IO       = 4'h6,
    PIC_CMD_LONG     = 4'h7,
    PIC_CMD_SET_BC   = 4'h8,
    PIC_CMD_TOG_B    = 4'h9
  } pic_cmd_t;

  // ALU operation kinds.
  typedef enum logic [1:0] {
    PIC_ALU_ARITH = 2'h0,
    PIC_ALU_LOGIC = 2'h1,
    PIC_ALU_SHIFT = 2'h2
  } pic_alu_t;

  // Core sequencing states.
  typedef enum logic [1:0] {
    PIC_ST_RUN  = 2'h0,
    PIC_ST_ACK  = 2'h1,
    PIC_ST_CALL = 2'h2
  } pic_state_t;

  // Acknowledge opcodes and vectors per level.
  localparam logic [7:0] PIC_ACK_OP [8] = '{8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hE8, 8'hF0, 8'hF8, 8'hFC};
  localparam logic [11:0] PIC_VEC [8] = '{12'h040, 12'h080, 12'h0C0, 12'h100,
                                         12'h140, 12'h180, 12'h1C0, 12'h1E0};

endpackage

/* File: hdl/pic_ctrl.sv */
// What this block does
// - Eight-bit pending and active registers per level.
// - Latch requests each non-I/O instruction cycle.
// - Request only if no higher level active.
// - Acknowledge pushes PC, calls level vector.
// - Return sets enable, clears level bits.
// - Disabled: keep logging, defer servicing.
// - Repeat request on set pending bit lost.
// - Reset clears enable, pending, active.
// - Off clears enable; on/return/sleep set.
// - Edge to service in 3-5 machine cycles.
// - Fixed priority, level 7 highest, vectors.
// - Map hardware sources onto levels 1-6.
// - Each source masked individually.
// - Soft interrupt writes pending bits.
// - Four-bit flags: branch, carry, enable.
// - Carry from arithmetic; boolean keeps it.
// - Branch taken when branch flag set.
// - Machine cycle two clocks; one/four cycles.
//
// The placing of the registers and register access over APB were chosen for this implementation.
module pic_ctrl
  import pic_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eeprom_done,
  input  wire logic [3:0]  port3_line,
  input  wire logic        timer1_evt,
  input  wire logic [3:0]  timer2_evt,
  input  wire logic        input_line_forty,
  output logic             mc_strobe,
  output logic             cpu_irq_req,
  output logic             ack_cycle,
  output logic [7:0]       ack_opcode,
  output logic [11:0]      call_vector,
  output logic             branch_taken,
  output logic             irq
);

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic [3:0]  condition_flags_reg;
  logic [7:0]  pending_reg;
  logic [7:0]  active_reg;
  logic [10:0] src_mask_reg;
  logic [3:0]  p3_prev_reg;
  logic        in40_prev_reg;
  logic        phase_reg;
  logic [1:0]  long_cnt_reg;
  logic        io_cycle_reg;
  logic [2:0]  level_reg;
  logic [3:0]  stat_reg;
  logic [3:0]  imask_reg;
  logic [11:0] pc_push_reg;
  pic_state_t  state_reg;

  // ----------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  hw_req;
  logic [7:0]  soft_req;
  logic        mc_end;
  logic        instr_end;
  logic [7:0]  eligible;
  logic [2:0]  top_level;
  logic        top_valid;
  logic        cmd_wr;
  pic_cmd_t    cmd;
  logic        ret_now;
  logic [7:0]  ret_clear;

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign cmd_wr = wr_en && (paddr == PIC_OFS_CMD);
  assign cmd    = pic_cmd_t'(pwdata[3:0]);

  // A machine cycle ends every second clock; long instructions span four.
  assign mc_end    = phase_reg;
  assign instr_end = mc_end && (long_cnt_reg == 2'h0);

  // Falling edges and events, each gated by its own mask bit.
  always_comb begin
    hw_req    = 8'h00;
    hw_req[1] = eeprom_done && src_mask_reg[PIC_SRC_EEPROM];
    hw_req[2] = (p3_prev_reg[0] && !port3_line[0] && src_mask_reg[PIC_SRC_P3L0]) ||
                (p3_prev_reg[1] && !port3_line[1] && src_mask_reg[PIC_SRC_P3L1]);
    hw_req[3] = (p3_prev_reg[2] && !port3_line[2] && src_mask_reg[PIC_SRC_P3L2]) ||
                (p3_prev_reg[3] && !port3_line[3] && src_mask_reg[PIC_SRC_P3L3]);
    hw_req[4] = timer1_evt && src_mask_reg[PIC_SRC_TMR1];
    hw_req[5] = |(timer2_evt & src_mask_reg[PIC_SRC_TBP:PIC_SRC_TAS]);
    hw_req[6] = in40_prev_reg && !input_line_forty && src_mask_reg[PIC_SRC_IN40];
  end

  // Soft interrupt writes two nibbles taken from command write data bits 11:4.
  assign soft_req = (cmd_wr && cmd == PIC_CMD_SOFT_IRQ) ? pwdata[11:4] : 8'h00;

  // Return clears the highest active level.
  assign ret_now = cmd_wr && (cmd == PIC_CMD_RETURN);

  // Pending levels above every active level compete.
  always_comb begin
    eligible  = 8'h00;
    top_level = 3'h0;
    top_valid = 1'b0;
    ret_clear = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (pending_reg[i] && !active_reg[i] && ((active_reg >> i) == 8'h00)) begin
        eligible[i] = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (eligible[i]) begin
        top_level = 3'(i);
        top_valid = 1'b1;
      end
      if (active_reg[i]) begin
        ret_clear    = 8'h00;
        ret_clear[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // Machine cycle timing
  // ----------------------------------------------------------
  // Phase toggles each clock; the long count tracks four-cycle instructions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg    <= 1'b0;
      long_cnt_reg <= 2'h0;
      io_cycle_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (cmd_wr && cmd == PIC_CMD_LONG && long_cnt_reg == 2'h0) begin
        long_cnt_reg <= PIC_LONG_INSTR_MC;
      end else if (mc_end && long_cnt_reg != 2'h0) begin
        long_cnt_reg <= long_cnt_reg - 2'h1;
      end
      if (cmd_wr && cmd == PIC_CMD_IO) begin
        io_cycle_reg <= 1'b1;
      end else if (instr_end) begin
        io_cycle_reg <= 1'b0;
      end
    end
  end

  // Previous pin levels for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p3_prev_reg   <= 4'hF;
      in40_prev_reg <= 1'b1;
    end else begin
      p3_prev_reg   <= port3_line;
      in40_prev_reg <= input_line_forty;
    end
  end

  // ----------------------------------------------------------
  // Pending register
  // ----------------------------------------------------------
  // Hardware events are caught as they come; they merge into a set bit.
  // They enter only outside an I/O instruction cycle, else stay captured.
  logic [7:0] hw_hold_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_hold_reg <= 8'h00;
      pending_reg <= 8'h00;
    end else begin
      if (instr_end && !io_cycle_reg) begin
        hw_hold_reg <= 8'h00;
        pending_reg <= (pending_reg & ~(ret_now ? ret_clear : 8'h00)) | hw_hold_reg | hw_req | soft_req;
      end else begin
        hw_hold_reg <= hw_hold_reg | hw_req;
        pending_reg <= (pending_reg & ~(ret_now ? ret_clear : 8'h00)) | soft_req;
      end
    end
  end

  // ----------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------
  // A level can be active only once, so one saved address per level covers
  // the deepest nesting; a return restores the highest active level's slot.
  logic [11:0] pc_reg;
  logic [11:0] ret_stack_reg [8];
  logic [2:0]  ret_level;

  // Picks the level that a return will close.
  always_comb begin
    ret_level = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (active_reg[i]) begin
        ret_level = 3'(i);
      end
    end
  end

  // The counter steps once per instruction; the call jumps, the return reloads.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= 12'h000;
    end else if (state_reg == PIC_ST_ACK && mc_end) begin
      pc_reg <= PIC_VEC[level_reg];
    end else if (ret_now && active_reg != 8'h00) begin
      pc_reg <= ret_stack_reg[ret_level];
    end else if (instr_end) begin
      pc_reg <= pc_reg + 12'h001;
    end
  end

  // The acknowledge saves the interrupted address in its level's slot.
  always_ff @(posedge pclk) begin
    if (state_reg == PIC_ST_ACK && mc_end) begin
      ret_stack_reg[level_reg] <= pc_reg;
    end
  end

  // ----------------------------------------------------------
  // Acknowledge sequencing and active register
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= PIC_ST_RUN;
      active_reg  <= 8'h00;
      level_reg   <= 3'h0;
      ack_cycle   <= 1'b0;
      ack_opcode  <= 8'h00;
      call_vector <= 12'h000;
      pc_push_reg <= 12'h000;
      cpu_irq_req <= 1'b0;
    end else begin
      cpu_irq_req <= top_valid;
      ack_cycle   <= 1'b0;
      if (ret_now) begin
        active_reg <= active_reg & ~ret_clear;
      end
      case (state_reg)
        PIC_ST_RUN: begin
          if (instr_end && top_valid && condition_flags_reg[PIC_FLAG_IE]) begin
            level_reg <= top_level;
            state_reg <= PIC_ST_ACK;
          end
        end
        PIC_ST_ACK: begin
          if (mc_end) begin
            active_reg[level_reg] <= 1'b1;
            ack_cycle   <= 1'b1;
            ack_opcode  <= PIC_ACK_OP[level_reg];
            call_vector <= PIC_VEC[level_reg];
            pc_push_reg <= pc_reg;
            state_reg   <= PIC_ST_CALL;
          end
        end
        PIC_ST_CALL: begin
          if (mc_end) begin
            state_reg <= PIC_ST_RUN;
          end
        end
        default: begin
          state_reg <= PIC_ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Condition flags
  // ----------------------------------------------------------
  // ALU write: [1:0] kind, [5:2] a, [9:6] b, [10] subtract.
  logic [4:0] alu_sum;
  pic_alu_t   alu_kind;
  assign alu_kind = pic_alu_t'(pwdata[1:0]);
  assign alu_sum  = pwdata[10] ? ({1'b0, pwdata[5:2]} - {1'b0, pwdata[9:6]})
                               : ({1'b0, pwdata[5:2]} + {1'b0, pwdata[9:6]});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_flags_reg <= PIC_FLAGS_RST;
    end else if (cmd_wr) begin
      case (cmd)
        PIC_CMD_IRQ_OFF:  condition_flags_reg[PIC_FLAG_IE] <= 1'b0;
        PIC_CMD_IRQ_ON,
        PIC_CMD_RETURN,
        PIC_CMD_SLEEP:    condition_flags_reg[PIC_FLAG_IE] <= 1'b1;
        PIC_CMD_SET_BC: begin
          condition_flags_reg[PIC_FLAG_BRANCH] <= 1'b1;
          condition_flags_reg[PIC_FLAG_CARRY]  <= 1'b1;
        end
        PIC_CMD_TOG_B:    condition_flags_reg[PIC_FLAG_BRANCH] <= ~condition_flags_reg[PIC_FLAG_BRANCH];
        default: begin
        end
      endcase
    end else if (wr_en && paddr == PIC_OFS_FLAGS) begin
      condition_flags_reg <= {1'b0, pwdata[2:0]};
    end else if (wr_en && paddr == PIC_OFS_ALU) begin
      case (alu_kind)
        PIC_ALU_ARITH: begin
          condition_flags_reg[PIC_FLAG_CARRY]  <= alu_sum[4];
          condition_flags_reg[PIC_FLAG_BRANCH] <= alu_sum[4];
        end
        PIC_ALU_SHIFT: begin
          condition_flags_reg[PIC_FLAG_CARRY]  <= pwdata[5];
          condition_flags_reg[PIC_FLAG_BRANCH] <= pwdata[5];
        end
        default: begin
          condition_flags_reg[PIC_FLAG_BRANCH] <= (pwdata[5:2] == 4'h0);
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Source masks and processor interrupt
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_mask_reg <= PIC_SRC_MASK_RST;
      imask_reg    <= 4'h0;
    end else begin
      if (wr_en && paddr == PIC_OFS_SRC_MASK) begin
        src_mask_reg <= pwdata[10:0];
      end
      if (wr_en && paddr == PIC_OFS_IRQ_MASK) begin
        imask_reg <= pwdata[3:0];
      end
    end
  end

  // Sticky events: ack, return, lost request, soft request. Set beats clear.
  logic [3:0] evt;
  assign evt = {|soft_req, |(pending_reg & hw_req), ret_now, ack_cycle};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 4'h0;
    end else if (wr_en && paddr == PIC_OFS_IRQ_STAT) begin
      stat_reg <= (stat_reg & ~pwdata[3:0]) | evt;
    end else begin
      stat_reg <= stat_reg | evt;
    end
  end

  // ----------------------------------------------------------
  // Outputs and APB slave
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq          <= 1'b0;
      mc_strobe    <= 1'b0;
      branch_taken <= 1'b0;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
    end else begin
      irq          <= |(stat_reg & imask_reg);
      mc_strobe    <= mc_end;
      branch_taken <= condition_flags_reg[PIC_FLAG_BRANCH];
      pready       <= psel && !penable;
      pslverr      <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          PIC_OFS_FLAGS:    prdata <= {28'h0, condition_flags_reg};
          PIC_OFS_PENDING:  prdata <= {24'h0, pending_reg};
          PIC_OFS_ACTIVE:   prdata <= {24'h0, active_reg};
          PIC_OFS_SRC_MASK: prdata <= {21'h0, src_mask_reg};
          PIC_OFS_CMD:      prdata <= {30'h0, state_reg};
          PIC_OFS_ALU:      prdata <= 32'h0000_0000;
          PIC_OFS_IRQ_STAT: prdata <= {28'h0, stat_reg};
          PIC_OFS_IRQ_MASK: prdata <= {28'h0, imask_reg};
          PIC_OFS_VECTOR:   prdata <= {17'h0, level_reg, pc_push_reg};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

/* File: tb/pic_ctrl_assertions.sv */
// ------------------------------------------------------------
// Port checker for the interrupt controller
// ------------------------------------------------------------
module pic_ctrl_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        mc_strobe,
  input wire logic        cpu_irq_req,
  input wire logic        ack_cycle,
  input wire logic [7:0]  ack_opcode,
  input wire logic [11:0] call_vector
);
  // All checks run on the bus clock and sleep during reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_mc_period: assert property (mc_strobe |=> !mc_strobe ##1 mc_strobe)
    else $error("machine cycle not two clocks");
  a_ack_pulse: assert property (ack_cycle |=> !ack_cycle)
    else $error("acknowledge longer than one clock");
  a_ack_vector: assert property (ack_cycle |-> ack_opcode[7:6] == 2'h3 &&
    call_vector == (ack_opcode[2] ? 12'h1E0 : {3'h0, ack_opcode[5:3], 6'h00}))
    else $error("vector does not match opcode");
  a_ack_after_req: assert property (ack_cycle |-> $past(cpu_irq_req))
    else $error("acknowledge without request");
  a_reset_clear: assert property ($rose(presetn) |-> !cpu_irq_req && !ack_cycle)
    else $error("request alive after reset");
endmodule

/* File: tb/pic_src_model.sv */
// ------------------------------------------------------------
// Peripheral sources driving the request pins
// ------------------------------------------------------------
module pic_src_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [10:0] kick,
  output logic             eeprom_done,
  output logic [3:0]       port3_line,
  output logic             timer1_evt,
  output logic [3:0]       timer2_evt,
  output logic             input_line_forty
);
  logic [10:0] k1_reg;
  logic [10:0] k2_reg;
  // Delays each kick so the pins move one clock after the bench asks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k1_reg <= 11'h000;
      k2_reg <= 11'h000;
    end else begin
      k1_reg <= kick;
      k2_reg <= k1_reg;
    end
  end
  // Pins idle high and dip low for one machine cycle; events pulse once.
  assign port3_line       = ~(k1_reg[4:1] | k2_reg[4:1]);
  assign input_line_forty = ~(k1_reg[10] | k2_reg[10]);
  assign eeprom_done      = k1_reg[0];
  assign timer1_evt       = k1_reg[5];
  assign timer2_evt       = k1_reg[9:6];
endmodule

/* File: tb/tb_pic_ctrl.sv */
// ------------------------------------------------------------
// Self-checking bench for the interrupt controller
// ------------------------------------------------------------
module tb_pic_ctrl
  import pic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         LVL [11]   = '{1, 2, 2, 3, 3, 4, 5, 5, 5, 5, 6};
  localparam logic [31:0] ALU_IN [6] = '{32'h7C, 32'h15, 32'h01, 32'h44, 32'h54C, 32'h22};
  localparam logic [31:0] ALU_EX [6] = '{32'h3, 32'h2, 32'h3, 32'h0, 32'h3, 32'h3};
  localparam logic [31:0] CMD_IN [6] = '{32'h2, 32'h1, 32'h4, 32'h1, 32'h9, 32'h8};
  localparam logic [31:0] CMD_EX [6] = '{32'h7, 32'h3, 32'h7, 32'h3, 32'h2, 32'h3};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, err;
  logic [7:0]  paddr = 8'h00, ack_opcode;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] kick = 11'h000;
  logic [11:0] call_vector;
  logic        eeprom_done, timer1_evt, input_line_forty, mc_strobe, cpu_irq_req, ack_cycle, branch_taken, irq;
  logic [3:0]  port3_line, timer2_evt;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #25 pclk = ~pclk;

  pic_src_model pic_src_model_i (.pclk(pclk), .presetn(presetn), .kick(kick), .eeprom_done(eeprom_done),
    .port3_line(port3_line), .timer1_evt(timer1_evt), .timer2_evt(timer2_evt), .input_line_forty(input_line_forty));
  pic_ctrl pic_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_done(eeprom_done), .port3_line(port3_line), .timer1_evt(timer1_evt), .timer2_evt(timer2_evt),
    .input_line_forty(input_line_forty), .mc_strobe(mc_strobe), .cpu_irq_req(cpu_irq_req),
    .ack_cycle(ack_cycle), .ack_opcode(ack_opcode), .call_vector(call_vector),
    .branch_taken(branch_taken), .irq(irq));

  // Prints the counts and the verdict, then stops the run.
  task give_verdict;
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, entered just after a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin chk("pready", 1, 0); give_verdict; end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  // Reads until the value appears or the bound runs out.
  task poll(input string nm, input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    do begin apb(0, a, 0); n++; end while (rd !== e && n < 12);
    chk(nm, e, rd);
    if (rd !== e) give_verdict;
  endtask

  task fire(input logic [10:0] m);
    kick <= m;
    @(posedge pclk);
    kick <= 11'h000;
    @(posedge pclk);
  endtask

  task wait_ack(input int lv, input int max);
    int n;
    n = 0;
    do begin @(posedge pclk); #1; n++; end while (ack_cycle !== 1'b1 && n < max);
    chk("ack_cycle", 1, ack_cycle);
    if (ack_cycle !== 1'b1) give_verdict;
    chk("ack_opcode", (lv == 7) ? 8'hFC : 8'hC8 + 8'(lv * 8), ack_opcode);
    chk("call_vector", (lv == 7) ? 12'h1E0 : 12'(lv + 1) * 12'h040, call_vector);
    @(posedge pclk);
  endtask

  // Masked sources stay silent; unmasked ones log while servicing is off.
  task t_sources;
    logic [7:0] acc;
    acc = 8'h00;
    fire(11'h7FF);
    repeat (8) @(posedge pclk);
    poll("pending", PIC_OFS_PENDING, 0);
    wr(PIC_OFS_SRC_MASK, 32'h7FF);
    for (int i = 0; i < 11; i++) begin
      fire(11'h001 << i);
      acc[LVL[i]] = 1'b1;
      poll("pending", PIC_OFS_PENDING, {24'h0, acc});
    end
    wr(PIC_OFS_CMD, 32'h815);
    poll("pending", PIC_OFS_PENDING, 32'hFF);
    poll("active", PIC_OFS_ACTIVE, 0);
    chk("cpu_irq_req", 1, cpu_irq_req);
  endtask

  // Serves all eight levels from the top down, then one timed pin edge.
  task t_service;
    wr(PIC_OFS_CMD, 32'h2);
    for (int lv = 7; lv >= 0; lv--) begin
      wait_ack(lv, 20);
      poll("active", PIC_OFS_ACTIVE, 32'h1 << lv);
      chk("cpu_irq_req", 0, cpu_irq_req);
      wr(PIC_OFS_CMD, 32'h3);
    end
    poll("pending", PIC_OFS_PENDING, 0);
    poll("active", PIC_OFS_ACTIVE, 0);
    poll("flags", PIC_OFS_FLAGS, 32'h4);
    fire(11'h400);
    wait_ack(6, 10);
    apb(0, PIC_OFS_VECTOR, 0);
    chk("level", 6, rd[14:12]);
    wr(PIC_OFS_CMD, 32'h3);
    poll("pending", PIC_OFS_PENDING, 0);
  endtask

  // Arithmetic, boolean and shift effects, then the direct flag commands.
  task t_flags;
    wr(PIC_OFS_CMD, 32'h1);
    poll("flags", PIC_OFS_FLAGS, 0);
    for (int i = 0; i < 6; i++) begin
      wr(PIC_OFS_ALU, ALU_IN[i]);
      poll("flags", PIC_OFS_FLAGS, ALU_EX[i]);
      chk("branch_taken", ALU_EX[i][0], branch_taken);
    end
    for (int i = 0; i < 6; i++) begin
      wr(PIC_OFS_CMD, CMD_IN[i]);
      poll("flags", PIC_OFS_FLAGS, CMD_EX[i]);
    end
  endtask

  // A repeated request is lost and flagged; the status line masks and clears.
  task t_lost;
    wr(PIC_OFS_IRQ_STAT, 32'hF);
    wr(PIC_OFS_IRQ_MASK, 32'h4);
    wr(PIC_OFS_CMD, 32'h105);
    fire(11'h001);
    fire(11'h001);
    poll("pending", PIC_OFS_PENDING, 32'h12);
    apb(0, PIC_OFS_IRQ_STAT, 0);
    chk("lost", 1, rd[2]);
    chk("irq", 1, irq);
    wr(PIC_OFS_IRQ_STAT, 32'h4);
    apb(0, PIC_OFS_IRQ_STAT, 0);
    chk("lost", 0, rd[2]);
    chk("irq", 0, irq);
    wr(PIC_OFS_IRQ_MASK, 32'h8);
    apb(0, PIC_OFS_IRQ_STAT, 0);
    chk("irq", 1, irq);
    wr(PIC_OFS_IRQ_STAT, 32'hF);
    apb(0, PIC_OFS_IRQ_STAT, 0);
    chk("irq", 0, irq);
    wr(PIC_OFS_CMD, 32'h7);
    wr(PIC_OFS_CMD, 32'h6);
    fire(11'h400);
    poll("pending", PIC_OFS_PENDING, 32'h52);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    poll("pending", PIC_OFS_PENDING, 0);
    poll("flags", PIC_OFS_FLAGS, 0);
    poll("src_mask", PIC_OFS_SRC_MASK, 0);
  endtask

  // Main sequence.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    poll("active", PIC_OFS_ACTIVE, 0);
    @(posedge pclk);
    err = mc_strobe;
    @(posedge pclk);
    chk("mc_strobe", !err, mc_strobe);
    apb(0, 8'h40, 32'h0);
    chk("pslverr", 1, err);
    chk("unmapped", 0, rd);
    t_sources();
    t_service();
    t_flags();
    t_lost();
    give_verdict;
  end
endmodule

bind pic_ctrl pic_ctrl_assertions pic_ctrl_assertions_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .mc_strobe(mc_strobe),
  .cpu_irq_req(cpu_irq_req), .ack_cycle(ack_cycle), .ack_opcode(ack_opcode), .call_vector(call_vector));
